// File: lhb_host_if.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Byte FIFO between the host ports and the controller core
// ----------------------------------------------------------------
module lhb_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_CNT = (AW+1)'(1);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   // Count moves only when one side acts alone
   assign cnt_nxt = (push && !pop) ? cnt_r + ONE_CNT :
                    (pop && !push) ? cnt_r - ONE_CNT : cnt_r;
   assign out_data = mem_r[rp_r];

   // Storage has no reset; contents are qualified by the count
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Pointers and registered flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) wp_r <= ptr_inc(wp_r);
         if (pop) rp_r <= ptr_inc(rp_r);
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != FULL_CNT);
         out_valid <= (cnt_nxt != '0);
      end
   end
endmodule

module lhb_host_if
   import lhb_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic E,
   input wire logic REGISTER_SELECT,
   input wire logic RW,
   input wire logic [DATA_W-1:0] PARALLEL_DATA_LINES_I,
   output logic [DATA_W-1:0] PARALLEL_DATA_LINES_O,
   output logic [DATA_W-1:0] PARALLEL_DATA_LINES_OE_N,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N,
   input wire logic [DATA_W-1:0] RD_DATA,
   output logic FOUR_BIT,
   output logic BUSY,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [DATA_W-1:0] RX_DATA,
   output logic RX_RS
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] par_s1_r;
   logic [SYNC_W-1:0] par_s2_r;
   logic e_q_r;
   logic [1:0] i2_s1_r;
   logic [1:0] i2_s2_r;
   logic [1:0] i2_q_r;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         par_s1_r <= '0;
         par_s2_r <= '0;
         e_q_r <= 1'b0;
         i2_s1_r <= 2'b11;
         i2_s2_r <= 2'b11;
         i2_q_r <= 2'b11;
      end else begin
         par_s1_r <= {E, REGISTER_SELECT, RW, PARALLEL_DATA_LINES_I};
         par_s2_r <= par_s1_r;
         e_q_r <= par_s2_r[SYNC_W-1];
         i2_s1_r <= {SCL_I, SDA_I};
         i2_s2_r <= i2_s1_r;
         i2_q_r <= i2_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // Parallel port decode
   // ----------------------------------------------------------------
   wire e_s = par_s2_r[SYNC_W-1];
   wire rs_s = par_s2_r[SYNC_W-2];
   wire rw_s = par_s2_r[SYNC_W-3];
   wire [DATA_W-1:0] db_s = par_s2_r[DATA_W-1:0];
   wire e_fall = e_q_r && !e_s;
   wire wr_fire = e_fall && !rw_s;
   logic four_bit_r;
   logic hi_phase_r;
   logic [NIB_W-1:0] hi_nib_r;
   // Lower lines are ignored in four-bit mode
   wire [DATA_W-1:0] par_byte = four_bit_r ? {hi_nib_r, db_s[DATA_W-1:NIB_W]} : db_s;
   wire byte_done = wr_fire && (!four_bit_r || !hi_phase_r);
   wire is_fset = byte_done && !rs_s && (par_byte[FSET_HI:FSET_LO] == FSET_CODE);
   wire [NIB_W-1:0] rd_nib = hi_phase_r ? RD_DATA[DATA_W-1:NIB_W] : RD_DATA[NIB_W-1:0];
   wire rd_drive = e_s && rw_s;

   // Bus width, nibble phase and high-nibble holding register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         four_bit_r <= 1'b0;
         hi_phase_r <= 1'b1;
         hi_nib_r <= '0;
      end else begin
         if (wr_fire && four_bit_r && hi_phase_r) hi_nib_r <= db_s[DATA_W-1:NIB_W];
         if (is_fset) begin
            four_bit_r <= !par_byte[FSET_DL];
            hi_phase_r <= 1'b1;
         end else if (e_fall && four_bit_r) begin
            hi_phase_r <= !hi_phase_r;
         end
      end
   end

   // Read drive; in four-bit mode only the upper lines, nibble by phase
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PARALLEL_DATA_LINES_O <= '0;
         PARALLEL_DATA_LINES_OE_N <= OE_ALL_OFF;
      end else if (rd_drive && four_bit_r) begin
         PARALLEL_DATA_LINES_O <= {rd_nib, NIB_ZERO};
         PARALLEL_DATA_LINES_OE_N <= OE_UPPER_ON;
      end else if (rd_drive) begin
         PARALLEL_DATA_LINES_O <= RD_DATA;
         PARALLEL_DATA_LINES_OE_N <= OE_ALL_ON;
      end else begin
         PARALLEL_DATA_LINES_O <= '0;
         PARALLEL_DATA_LINES_OE_N <= OE_ALL_OFF;
      end
   end

   // ----------------------------------------------------------------
   // Two-wire slave
   // ----------------------------------------------------------------
   lhb_i2c_t st_r;
   logic [DATA_W-1:0] sh_r;
   logic [3:0] cnt_r;
   logic rd_mode_r;
   logic first_r;
   logic i2_rs_r;
   logic fifo_in_ready;
   wire scl_s = i2_s2_r[1];
   wire sda_s = i2_s2_r[0];
   wire scl_rise = scl_s && !i2_q_r[1];
   wire scl_fall = !scl_s && i2_q_r[1];
   wire start_c = scl_s && i2_q_r[0] && !sda_s;
   wire stop_c = scl_s && !i2_q_r[0] && sda_s;
   wire byte_end = scl_fall && (cnt_r == BITS_PER_BYTE);
   wire addr_hit = (sh_r[DATA_W-1:1] == SLAVE_ADDR);
   wire i2_push = (st_r == I2_WR) && byte_end && !first_r;

   // Open-drain data: the block only ever pulls low, and SCL is input only
   // so no internal operation can stretch the clock
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_r <= I2_IDLE;
         sh_r <= '0;
         cnt_r <= '0;
         rd_mode_r <= 1'b0;
         first_r <= 1'b0;
         i2_rs_r <= 1'b0;
         SDA_OE_N <= 1'b1;
      end else if (start_c) begin
         st_r <= I2_ADDR;
         cnt_r <= '0;
         first_r <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else if (stop_c) begin
         st_r <= I2_IDLE;
         SDA_OE_N <= 1'b1;
      end else begin
         unique case (st_r)
            I2_IDLE: begin
            end
            I2_ADDR, I2_WR: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[DATA_W-2:0], sda_s};
                  cnt_r <= cnt_r + BIT_ONE;
               end else if (byte_end) begin
                  cnt_r <= '0;
                  if (st_r == I2_ADDR) begin
                     st_r <= addr_hit ? I2_ACKA : I2_IDLE;
                     SDA_OE_N <= !addr_hit;
                     rd_mode_r <= sh_r[0];
                  end else begin
                     st_r <= I2_ACKW;
                     // A full FIFO refuses the byte with no acknowledge
                     SDA_OE_N <= !(first_r || fifo_in_ready);
                     first_r <= 1'b0;
                     if (first_r) i2_rs_r <= sh_r[CTRL_RS_BIT];
                  end
               end
            end
            I2_ACKA: begin
               if (scl_fall && rd_mode_r) begin
                  st_r <= I2_RD;
                  sh_r <= {RD_DATA[DATA_W-2:0], 1'b0};
                  SDA_OE_N <= RD_DATA[DATA_W-1];
                  cnt_r <= BIT_ONE;
               end else if (scl_fall) begin
                  st_r <= I2_WR;
                  SDA_OE_N <= 1'b1;
               end
            end
            I2_ACKW: begin
               if (scl_fall) begin
                  st_r <= I2_WR;
                  SDA_OE_N <= 1'b1;
               end
            end
            I2_RD: begin
               if (byte_end) begin
                  st_r <= I2_MACK;
                  SDA_OE_N <= 1'b1;
                  cnt_r <= BIT_ZERO;
               end else if (scl_fall) begin
                  SDA_OE_N <= sh_r[DATA_W-1];
                  sh_r <= {sh_r[DATA_W-2:0], 1'b0};
                  cnt_r <= cnt_r + BIT_ONE;
               end
            end
            I2_MACK: begin
               if (scl_rise && sda_s) begin
                  st_r <= I2_IDLE;
               end else if (scl_rise) begin
                  cnt_r <= BIT_ONE;
               end else if (scl_fall && cnt_r == BIT_ONE) begin
                  st_r <= I2_RD;
                  sh_r <= {RD_DATA[DATA_W-2:0], 1'b0};
                  SDA_OE_N <= RD_DATA[DATA_W-1];
               end
            end
            default: begin
               st_r <= I2_IDLE;
               SDA_OE_N <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Byte FIFO towards the core; the parallel port wins a collision
   // ----------------------------------------------------------------
   wire par_push = byte_done;
   wire fifo_valid = par_push || i2_push;
   wire [FIFO_W-1:0] fifo_din = par_push ? {rs_s, par_byte} : {i2_rs_r, sh_r};
   wire [FIFO_W-1:0] fifo_dout;

   lhb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK),
      .rst(RST),
      .in_valid(fifo_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_din),
      .out_valid(RX_VALID),
      .out_ready(RX_READY),
      .out_data(fifo_dout)
   );

   // Status outputs and data out of registers
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         SDA_O <= 1'b0;
         BUSY <= 1'b0;
         FOUR_BIT <= 1'b0;
         RX_DATA <= '0;
         RX_RS <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
         BUSY <= !fifo_in_ready;
         FOUR_BIT <= four_bit_r;
         RX_DATA <= fifo_dout[DATA_W-1:0];
         RX_RS <= fifo_dout[FIFO_W-1];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_hi_write;
      wr_fire && four_bit_r && hi_phase_r && !is_fset;
   endsequence
   property p_byte8;
      @(posedge REF_CLK) disable iff (RST)
         (wr_fire && !four_bit_r) |-> byte_done && fifo_din[DATA_W-1:0] == db_s;
   endproperty
   a_byte8: assert property (p_byte8) else $error("8-bit write not taken");
   property p_nib_order;
      @(posedge REF_CLK) disable iff (RST)
         s_hi_write |=> !hi_phase_r && hi_nib_r == $past(db_s[DATA_W-1:NIB_W]);
   endproperty
   a_nib_order: assert property (p_nib_order) else $error("high nibble lost");
   property p_no_half_byte;
      @(posedge REF_CLK) disable iff (RST)
         s_hi_write |-> !byte_done;
   endproperty
   a_no_half_byte: assert property (p_no_half_byte) else $error("half byte pushed");
   property p_phase;
      @(posedge REF_CLK) disable iff (RST)
         (e_fall && four_bit_r && !is_fset) |=> hi_phase_r != $past(hi_phase_r);
   endproperty
   a_phase: assert property (p_phase) else $error("nibble phase stuck");
   property p_mode;
      @(posedge REF_CLK) disable iff (RST)
         $changed(four_bit_r) |-> $past(is_fset);
   endproperty
   a_mode: assert property (p_mode) else $error("mode changed without instruction");
   property p_low_free;
      @(posedge REF_CLK) disable iff (RST)
         four_bit_r |=> PARALLEL_DATA_LINES_OE_N[NIB_W-1:0] == OE_ALL_OFF[NIB_W-1:0];
   endproperty
   a_low_free: assert property (p_low_free) else $error("lower lines driven");
   property p_rd_drive;
      @(posedge REF_CLK) disable iff (RST)
         rd_drive |=> PARALLEL_DATA_LINES_OE_N[DATA_W-1] == 1'b0;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_addr_ack;
      @(posedge REF_CLK) disable iff (RST)
         (st_r == I2_ADDR && byte_end && !start_c && !stop_c) |=>
            (SDA_OE_N == !$past(addr_hit)) && (st_r == ($past(addr_hit) ? I2_ACKA : I2_IDLE));
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address answer wrong");
   property p_ack_hold;
      @(posedge REF_CLK) disable iff (RST)
         // Looked at one cycle on, so the last high sample before SCL falls is covered
         ((st_r == I2_ACKA || st_r == I2_ACKW) && !SDA_OE_N && scl_s) |=> !SDA_OE_N;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack released early");
   property p_nack_release;
      @(posedge REF_CLK) disable iff (RST)
         (st_r == I2_MACK && scl_rise && sda_s && !start_c && !stop_c) |=>
            st_r == I2_IDLE && SDA_OE_N [*2];
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("data not released");
endmodule

// File: lhb_host_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Host model: parallel bus master and two-wire bus master
// ----------------------------------------------------------------
module lhb_host_model (
   input wire logic clk,
   output logic e,
   output logic reg_sel,
   output logic rw,
   output logic [7:0] pdl_i,
   input wire logic [7:0] pdl_o,
   input wire logic [7:0] pdl_oe_n,
   output logic scl,
   output logic sda_i,
   input wire logic sda_oe_n
);
   logic [7:0] drv_m;
   logic [7:0] en_m;
   logic sda_m;

   // Wire levels: device drive, else host drive, else the pull-ups
   assign pdl_i = (~pdl_oe_n & pdl_o) | (pdl_oe_n & en_m & drv_m) | (pdl_oe_n & ~en_m);
   assign sda_i = sda_m & sda_oe_n;

   initial begin
      e = 1'b0;
      reg_sel = 1'b0;
      rw = 1'b0;
      drv_m = 8'h00;
      en_m = 8'h00;
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // One enable cycle, 400 ns; control and data held 4 cycles past the fall
   task automatic par_cyc(input logic rs, input logic r, input logic [7:0] d,
                          input logic [7:0] en, output logic [7:0] q, output logic [7:0] oe);
      @(negedge clk);
      reg_sel = rs;
      rw = r;
      drv_m = d;
      en_m = r ? 8'h00 : en;
      @(negedge clk) e = 1'b1;
      repeat (4) @(negedge clk);
      q = pdl_i;
      oe = pdl_oe_n;
      e = 1'b0;
      repeat (4) @(negedge clk);
      en_m = 8'h00;
   endtask

   // Start only from an idle bus; the bench always stops before starting
   task automatic i2c_start();
      @(negedge clk);
      scl = 1'b1;
      sda_m = 1'b1;
      repeat (4) @(negedge clk);
      sda_m = 1'b0;
      repeat (4) @(negedge clk);
      scl = 1'b0;
   endtask

   task automatic i2c_stop();
      @(negedge clk) sda_m = 1'b0;
      repeat (3) @(negedge clk);
      scl = 1'b1;
      repeat (4) @(negedge clk);
      sda_m = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // Data changes one cycle after the clock falls, never beside an edge
   task automatic clk_bit(input logic b, output logic s1, output logic s2);
      @(negedge clk) sda_m = b;
      repeat (3) @(negedge clk);
      scl = 1'b1;
      @(negedge clk) s1 = sda_i;
      repeat (3) @(negedge clk);
      s2 = sda_i;
      scl = 1'b0;
   endtask

   // Byte plus ninth bit; mack low acknowledges a read byte
   task automatic i2c_byte(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic ack);
      logic s1;
      logic s2;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], s1, s2);
         rx[i] = s2;
      end
      clk_bit(mack, s1, s2);
      ack = ~s1 & ~s2;
   endtask
endmodule

// File: lhb_pkg.sv
package lhb_pkg;
   // ----------------------------------------------------------------
   // Widths and byte layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int SYNC_W = 11;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 9;
   // Function-set instruction: code in bits 7..5, data-length flag in bit 4
   localparam logic [2:0] FSET_CODE = 3'h1;
   localparam int FSET_HI = 7;
   localparam int FSET_LO = 5;
   localparam int FSET_DL = 4;
   // Control byte on the two-wire port: register select in bit 6
   localparam int CTRL_RS_BIT = 6;
   // Slave address: arbitrary value, adjust to the board
   localparam logic [6:0] SLAVE_ADDR = 7'h3B;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [7:0] OE_ALL_OFF = 8'hFF;
   localparam logic [7:0] OE_ALL_ON = 8'h00;
   localparam logic [7:0] OE_UPPER_ON = 8'h0F;
   localparam logic [3:0] NIB_ZERO = 4'h0;

   // ----------------------------------------------------------------
   // Two-wire slave states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      I2_IDLE = 3'b000,
      I2_ADDR = 3'b001,
      I2_ACKA = 3'b010,
      I2_WR = 3'b011,
      I2_ACKW = 3'b100,
      I2_RD = 3'b101,
      I2_MACK = 3'b110
   } lhb_i2c_t;
endpackage

// File: tb_lcd_host_bus_interface.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Self-checking bench for the host bus interface
// ----------------------------------------------------------------
module tb_lcd_host_bus_interface
   import lhb_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic e, reg_sel, rw, scl, sda_i, sda_o, sda_oe_n, four_bit, busy, rx_valid, rx_rs;
   logic rx_ready = 1'b0;
   logic [7:0] pdl_i, pdl_o, pdl_oe_n, rx_data;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] q, b;
   logic [7:0] w [2];
   logic ack;
   logic mode4 = 1'b0;
   int failures = 0;
   int cmp_count = 0;
   integer seed = 32'haa00;

   always #20 ref_clk = ~ref_clk;

   lhb_host_if dut_u (.REF_CLK(ref_clk), .RST(rst), .E(e), .REGISTER_SELECT(reg_sel), .RW(rw),
      .PARALLEL_DATA_LINES_I(pdl_i), .PARALLEL_DATA_LINES_O(pdl_o),
      .PARALLEL_DATA_LINES_OE_N(pdl_oe_n), .SCL_I(scl), .SDA_I(sda_i), .SDA_O(sda_o),
      .SDA_OE_N(sda_oe_n), .RD_DATA(rd_data), .FOUR_BIT(four_bit), .BUSY(busy),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_RS(rx_rs));

   lhb_host_model host_u (.clk(ref_clk), .e(e), .reg_sel(reg_sel), .rw(rw), .pdl_i(pdl_i),
      .pdl_o(pdl_o), .pdl_oe_n(pdl_oe_n), .scl(scl), .sda_i(sda_i), .sda_oe_n(sda_oe_n));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] fset(input logic four);
      return {FSET_CODE, ~four, 4'h0};
   endfunction

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Data follows the valid flag by a cycle, so sample two cycles later
   task automatic pop(input logic [8:0] exp);
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 100) begin
         failures++;
         end_of_test();
      end
      repeat (2) @(negedge ref_clk);
      chk({rx_rs, rx_data}, exp);
      rx_ready = 1'b1;
      @(negedge ref_clk) rx_ready = 1'b0;
      @(negedge ref_clk);
   endtask

   // Four-bit writes leave the lower lines to the pull-ups
   task automatic wr(input logic rs, input logic [7:0] d);
      logic [7:0] o;
      logic [7:0] x;
      if (mode4) begin
         host_u.par_cyc(rs, 1'b0, {d[7:4], 4'h0}, 8'hF0, x, o);
         chk({8'h00, rx_valid}, 9'h000);
         host_u.par_cyc(rs, 1'b0, {d[3:0], 4'h0}, 8'hF0, x, o);
      end else begin
         host_u.par_cyc(rs, 1'b0, d, 8'hFF, x, o);
      end
   endtask

   // Busy read, both nibble cycles completed in four-bit mode
   task automatic rd(output logic [7:0] d);
      logic [7:0] q1, o1, q2, o2;
      host_u.par_cyc(1'b0, 1'b1, 8'h00, 8'h00, q1, o1);
      if (mode4) begin
         host_u.par_cyc(1'b0, 1'b1, 8'h00, 8'h00, q2, o2);
         chk({o1 === o2, o1}, 9'h10F);
         d = {q1[7:4], q2[7:4]};
      end else begin
         chk({1'b0, o1}, 9'h000);
         d = q1;
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      chk({busy, pdl_oe_n}, 9'h0FF);
      chk({7'h00, four_bit, rx_valid}, 9'h000);
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         b = $random(seed);
         // Keep random bytes off the width instruction code
         if (b[7:5] == FSET_CODE) b[6] = 1'b1;
         wr(b[7], b);
         pop({b[7], b});
         rd_data = $random(seed);
         rd(q);
         chk({1'b0, q}, {1'b0, rd_data});
      end
      // A function-set pattern sent as data must not change the width
      wr(1'b1, fset(1'b1));
      pop({1'b1, fset(1'b1)});
      chk({8'h00, four_bit}, 9'h000);
      wr(1'b0, fset(1'b1));
      pop({1'b0, fset(1'b1)});
      chk({8'h00, four_bit}, 9'h001);
      mode4 = 1'b1;
      $display("test eight bit done");
      for (int i = 0; i < 3; i++) begin
         b = $random(seed);
         if (b[7:5] == FSET_CODE) b[6] = 1'b1;
         wr(b[0], b);
         pop({b[0], b});
         rd_data = $random(seed);
         rd(q);
         chk({1'b0, q}, {1'b0, rd_data});
      end
      wr(1'b0, fset(1'b0));
      pop({1'b0, fset(1'b0)});
      chk({8'h00, four_bit}, 9'h000);
      mode4 = 1'b0;
      $display("test four bit done");
      // Fill the buffer until it refuses, then drain it
      for (int i = 0; i < 9; i++) begin
         if (i == 7) chk({8'h00, busy}, 9'h000);
         wr(1'b1, 8'h10 + i[7:0]);
         if (i == 7) chk({8'h00, busy}, 9'h001);
      end
      for (int i = 0; i < 8; i++) pop({1'b1, 8'h10 + i[7:0]});
      chk({7'h00, busy, rx_valid}, 9'h000);
      $display("test buffer done");
      // Two-wire write: address, control byte with select set, two data bytes
      host_u.i2c_start();
      host_u.i2c_byte({SLAVE_ADDR, 1'b0}, 1'b1, q, ack);
      chk({8'h00, ack}, 9'h001);
      host_u.i2c_byte(8'h40, 1'b1, q, ack);
      chk({8'h00, ack}, 9'h001);
      for (int i = 0; i < 2; i++) begin
         w[i] = $random(seed);
         host_u.i2c_byte(w[i], 1'b1, q, ack);
         chk({8'h00, ack}, 9'h001);
      end
      host_u.i2c_stop();
      for (int i = 0; i < 2; i++) pop({1'b1, w[i]});
      host_u.i2c_start();
      host_u.i2c_byte({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
      chk({8'h00, ack}, 9'h000);
      host_u.i2c_stop();
      $display("test serial write done");
      // Two-wire read: acknowledged byte, then the last byte left unacknowledged
      rd_data = $random(seed);
      host_u.i2c_start();
      host_u.i2c_byte({SLAVE_ADDR, 1'b1}, 1'b1, q, ack);
      chk({8'h00, ack}, 9'h001);
      host_u.i2c_byte(8'hFF, 1'b0, q, ack);
      chk({1'b0, q}, {1'b0, rd_data});
      host_u.i2c_byte(8'hFF, 1'b1, q, ack);
      chk({ack, q}, {1'b0, rd_data});
      repeat (4) @(negedge ref_clk);
      chk({8'h00, sda_i}, 9'h001);
      chk({8'h00, sda_o}, 9'h000);
      host_u.i2c_stop();
      $display("test serial read done");
      end_of_test();
   end
endmodule
